/* File: hdl/dacs_cfg.svh */
// Constants of the dual-channel conversion sequencer: offsets, fields, resets, timing.
// Assumes a 40 MHz pclk; every time below is turned into pclk cycles here.
// Overview of operation
// (R01) Busy high at most 1.75 us normal, 2 us reduced, except read-after.
// (R02) First channel end-of-conversion high at most 1 us normal, 1.25 us reduced.
// (R03) End-of-conversion low at least 45 ns between the two channels.
// (R04) Second channel end-of-conversion high at most 0.75 us.
// (R05) Busy falls at least 10 ns after both conversions end.
// (R06) Parallel data valid within 1.75 / 2 us of the convert request.
// (R07) Parallel data valid at least 14 ns before busy falls.
// (R08) Read-during frame marker rises 250 / 500 ns after the convert request.
// (R09) Divider codes 00..11 give serial clock periods of at least 25/50/100/200 ns.
// (R10) Typical serial clock periods 40/70/140/280 ns per divider code.
// (R11) Read-after busy, normal power, at most 3.25/4.25/6.25/10.75 us.
// (R12) Read-after busy, reduced power, at most 3.5/4.5/6.5/11 us.
// (R13) First serial clock edge at least 3 ns (00) or 17 ns after frame marker.
// (R14) Last serial clock edge to frame marker change at least 1/3/30/80 ns.
// (R15) Read-after frame marker rises 0.75 / 1 us after the convert request.
// (R16) Read-after busy falls about 25 ns after frame marker falls.
// (R17) Both inputs of the selected pair are sampled together, then converted.
// (R18) Serial order: first channel first when order select high, else second first.
// (R19) Power-mode select high means reduced power with the longer limits.
// (R20) Port-type select low uses the parallel port, high the serial port.
// (R21) Host waits for busy low before a new request and before reading.
`ifndef DACS_CFG_SVH
`define DACS_CFG_SVH

`define DACS_OFF_CTRL      12'h000
`define DACS_OFF_STATUS    12'h004
`define DACS_OFF_RESULT    12'h008
`define DACS_CTRL_RESET    8'h00
`define DACS_ST_BUSY       0
`define DACS_ST_EOC        1
`define DACS_ST_FRAME      2
`define DACS_ST_PAIR       3

`define DACS_CLK_NS        25
`define DACS_CYC_UP(ns)    (((ns) + `DACS_CLK_NS - 1) / `DACS_CLK_NS)
`define DACS_CYC_DN(ns)    ((ns) / `DACS_CLK_NS)
`define DACS_SCK_CYC(ns)   ((`DACS_CYC_UP(ns) < 2) ? 2 : `DACS_CYC_UP(ns))

`define DACS_EOCA_NRM_NS   900
`define DACS_EOCA_RED_NS   1150
`define DACS_EOC_GAP_NS    45
`define DACS_EOCB_NS       500
`define DACS_TAIL_NS       10
`define DACS_RDC_NRM_NS    250
`define DACS_RDC_RED_NS    500
`define DACS_RAC_NRM_NS    750
`define DACS_RAC_RED_NS    1000
`define DACS_LEAD0_NS      3
`define DACS_LEAD_NS       17
`define DACS_SCK0_NS       25
`define DACS_SCK1_NS       50
`define DACS_SCK2_NS       100
`define DACS_SCK3_NS       200
`define DACS_TRAIL0_NS     1
`define DACS_TRAIL1_NS     3
`define DACS_TRAIL2_NS     30
`define DACS_TRAIL3_NS     80

`endif

/* File: hdl/dacs_pkg.sv */
// Types of the dual-channel conversion sequencer.
// Constants live in dacs_cfg.svh.
package dacs_pkg;

  typedef enum logic [2:0] {
    CV_IDLE = 3'b000,
    CV_EOCA = 3'b001,
    CV_GAP  = 3'b010,
    CV_EOCB = 3'b011,
    CV_TAIL = 3'b100,
    CV_HOLD = 3'b101
  } dacs_conv_type;

  typedef enum logic [2:0] {
    SR_IDLE  = 3'b000,
    SR_WAIT  = 3'b001,
    SR_LEAD  = 3'b010,
    SR_SHIFT = 3'b011,
    SR_TRAIL = 3'b100,
    SR_DONE  = 3'b101
  } dacs_ser_type;

  typedef struct packed {
    logic [1:0] serial_clock_divider;
    logic       read_after;
    logic       slave_mode;
    logic       input_pair_select;
    logic       channel_order;
    logic       port_type_select;
    logic       reduced_power;
  } dacs_ctrl_type;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } dacs_pair_type;

  typedef struct packed {
    dacs_ctrl_type ctrl;
    dacs_conv_type conv;
    logic [7:0]    conv_cnt;
    logic          busy;
    logic          eoc;
    logic          convert_request_n_q;
    logic          last_pair;
    dacs_pair_type held;
    dacs_pair_type result;
    logic [15:0]   par_data;
    dacs_ser_type  ser;
    logic [7:0]    ser_cnt;
    logic [5:0]    bit_cnt;
    logic          sync;
    logic          sclk;
    logic          ext_sclk_q;
    logic [31:0]   prdata;
    logic          pslverr;
  } dacs_state_type;

endpackage

/* File: hdl/dacs_clkdiv.sv */
// Serial clock divider: one-cycle tick every half_cycles pclk cycles while enabled.
// Assumes half_cycles is at least one.
`timescale 1ns/100ps
module dacs_clkdiv #(
  parameter int CW = 4
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control
  input  wire logic          en,
  input  wire logic [CW-1:0] half_cycles,
  output logic               tick
);
  typedef struct packed {
    logic [CW-1:0] cnt;
  } dacs_div_type;

  dacs_div_type s;
  dacs_div_type next_s;

  always_comb begin
    next_s = s;
    tick = 1'b0;
    if (!en) begin
      next_s.cnt = '0;
    end else if (s.cnt == half_cycles - CW'(1)) begin
      tick = 1'b1;
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: hdl/dacs_shifter.sv */
// Result shift register, most significant bit out first.
// Load wins over shift when both are asked in one cycle.
`timescale 1ns/100ps
module dacs_shifter #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control and data
  input  wire logic         load,
  input  wire logic [W-1:0] load_data,
  input  wire logic         shift,
  input  wire logic         shift_in,
  output logic              msb
);
  typedef struct packed {
    logic [W-1:0] data;
  } dacs_shr_type;

  dacs_shr_type s;
  dacs_shr_type next_s;

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.data = load_data;
    end else if (shift) begin
      next_s.data = {s.data[W-2:0], shift_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign msb = s.data[W-1];
endmodule

/* File: hdl/dacs_top.sv */
// Dual-channel conversion sequencer: convert timing, parallel and serial result ports, APB registers.
// Assumes all pin inputs synchronous to pclk; the analog core presents both pairs as steady words.
`timescale 1ns/100ps
`include "dacs_cfg.svh"
module dacs_top (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Conversion control and analog core
  input  wire logic                   convert_request_n,
  input  wire dacs_pkg::dacs_pair_type pair1,
  input  wire dacs_pkg::dacs_pair_type pair2,
  output logic                        busy,
  output logic                        eoc,
  // Parallel port
  output logic [15:0]                 par_data_out,
  output logic                        par_data_oe,
  // Serial port
  input  wire logic                   serial_select_n,
  input  wire logic                   ext_sclk_in,
  input  wire logic                   serial_chain_in,
  output logic                        serial_clk_out,
  output logic                        serial_clk_oe,
  output logic                        frame_marker_out,
  output logic                        frame_marker_oe,
  output logic                        serial_result_out,
  output logic                        serial_result_oe
);
  import dacs_pkg::*;

  dacs_state_type s;
  dacs_state_type next_s;

  logic        convert_request_n_fall;
  logic        master;
  logic        slave;
  logic [31:0] ordered;
  logic        sh_load;
  logic [31:0] sh_data;
  logic        sh_shift;
  logic        div_en;
  logic [3:0]  half_cyc;
  logic        div_tick;
  logic [7:0]  trail_cyc;
  logic [7:0]  lead_cyc;
  logic        sh_msb;

  dacs_clkdiv #(
    .CW(4)
  ) u_div (
    .pclk        (pclk),
    .presetn     (presetn),
    .en          (div_en),
    .half_cycles (half_cyc),
    .tick        (div_tick)
  );

  dacs_shifter #(
    .W(32)
  ) u_shr (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (sh_load),
    .load_data (sh_data),
    .shift     (sh_shift),
    .shift_in  (slave ? serial_chain_in : 1'b0),
    .msb       (sh_msb)
  );

  // Serial timing chosen by the divider code
  always_comb begin
    case (s.ctrl.serial_clock_divider)
      2'b00: begin
        half_cyc = 4'(`DACS_SCK_CYC(`DACS_SCK0_NS) / 2); // R09 R10
        trail_cyc = 8'(`DACS_CYC_UP(`DACS_TRAIL0_NS)); // R14
        lead_cyc = 8'(`DACS_CYC_UP(`DACS_LEAD0_NS)); // R13
      end
      2'b01: begin
        half_cyc = 4'(`DACS_SCK_CYC(`DACS_SCK1_NS) / 2); // R09 R10
        trail_cyc = 8'(`DACS_CYC_UP(`DACS_TRAIL1_NS)); // R14
        lead_cyc = 8'(`DACS_CYC_UP(`DACS_LEAD_NS)); // R13
      end
      2'b10: begin
        half_cyc = 4'(`DACS_SCK_CYC(`DACS_SCK2_NS) / 2); // R09 R10
        trail_cyc = 8'(`DACS_CYC_UP(`DACS_TRAIL2_NS)); // R14
        lead_cyc = 8'(`DACS_CYC_UP(`DACS_LEAD_NS)); // R13
      end
      default: begin
        half_cyc = 4'(`DACS_SCK_CYC(`DACS_SCK3_NS) / 2); // R09 R10
        trail_cyc = 8'(`DACS_CYC_UP(`DACS_TRAIL3_NS)); // R14
        lead_cyc = 8'(`DACS_CYC_UP(`DACS_LEAD_NS)); // R13
      end
    endcase
  end

  always_comb begin
    next_s = s;
    sh_load = 1'b0;
    sh_data = 32'h0;
    sh_shift = 1'b0;
    next_s.convert_request_n_q = convert_request_n;
    next_s.ext_sclk_q = ext_sclk_in;
    convert_request_n_fall = s.convert_request_n_q & ~convert_request_n;
    master = s.ctrl.port_type_select & ~s.ctrl.slave_mode; // R20
    slave = s.ctrl.port_type_select & s.ctrl.slave_mode; // R20
    if (s.ctrl.channel_order) begin
      ordered = {s.result.a, s.result.b}; // R18
    end else begin
      ordered = {s.result.b, s.result.a}; // R18
    end

    // APB: read data and error are caught in the setup cycle
    if (psel && !penable) begin
      next_s.pslverr = 1'b0;
      case (paddr)
        `DACS_OFF_CTRL: begin
          next_s.prdata = {24'h0, s.ctrl};
        end
        `DACS_OFF_STATUS: begin
          next_s.prdata = 32'h0;
          next_s.prdata[`DACS_ST_BUSY] = s.busy;
          next_s.prdata[`DACS_ST_EOC] = s.eoc;
          next_s.prdata[`DACS_ST_FRAME] = s.sync;
          next_s.prdata[`DACS_ST_PAIR] = s.last_pair;
        end
        `DACS_OFF_RESULT: begin
          next_s.prdata = {s.result.a, s.result.b};
        end
        default: begin
          next_s.prdata = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && paddr == `DACS_OFF_CTRL) begin
      next_s.ctrl = dacs_ctrl_type'(pwdata[7:0]);
    end

    // Conversion sequence
    case (s.conv)
      CV_IDLE: begin
        // A request while busy is simply not seen
        if (convert_request_n_fall) begin // R21
          if (s.ctrl.input_pair_select) begin
            next_s.held = pair2; // R17
          end else begin
            next_s.held = pair1; // R17
          end
          next_s.last_pair = s.ctrl.input_pair_select;
          next_s.conv = CV_EOCA;
          next_s.eoc = 1'b1;
          if (s.ctrl.reduced_power) begin
            next_s.conv_cnt = 8'(`DACS_CYC_DN(`DACS_EOCA_RED_NS) - 1); // R02 R19
          end else begin
            next_s.conv_cnt = 8'(`DACS_CYC_DN(`DACS_EOCA_NRM_NS) - 1); // R02
          end
        end
      end
      CV_EOCA: begin
        if (s.conv_cnt == 8'h00) begin
          next_s.result.a = s.held.a;
          next_s.eoc = 1'b0;
          next_s.conv = CV_GAP;
          next_s.conv_cnt = 8'(`DACS_CYC_UP(`DACS_EOC_GAP_NS) - 1); // R03
        end else begin
          next_s.conv_cnt = s.conv_cnt - 8'h01;
        end
      end
      CV_GAP: begin
        if (s.conv_cnt == 8'h00) begin
          next_s.eoc = 1'b1;
          next_s.conv = CV_EOCB;
          next_s.conv_cnt = 8'(`DACS_CYC_DN(`DACS_EOCB_NS) - 1); // R04
        end else begin
          next_s.conv_cnt = s.conv_cnt - 8'h01;
        end
      end
      CV_EOCB: begin
        if (s.conv_cnt == 8'h00) begin
          next_s.result.b = s.held.b;
          next_s.eoc = 1'b0;
          next_s.conv = CV_TAIL;
          next_s.conv_cnt = 8'(`DACS_CYC_UP(`DACS_TAIL_NS) - 1); // R05
        end else begin
          next_s.conv_cnt = s.conv_cnt - 8'h01;
        end
      end
      CV_TAIL: begin
        if (s.conv_cnt == 8'h00) begin
          if (master && s.ctrl.read_after) begin
            next_s.conv = CV_HOLD; // R11 R12
          end else begin
            next_s.conv = CV_IDLE; // R01 R05
          end
          if (slave) begin
            sh_load = 1'b1;
            sh_data = ordered; // R18
          end
        end else begin
          next_s.conv_cnt = s.conv_cnt - 8'h01;
        end
      end
      CV_HOLD: begin
        // Busy drops one cycle after the frame marker closes
        if (s.ser == SR_DONE || !master) begin
          next_s.conv = CV_IDLE; // R16
        end
      end
      default: begin
        next_s.conv = CV_IDLE;
      end
    endcase
    next_s.busy = (next_s.conv != CV_IDLE); // R01
    // Taken from the next result so data leads busy by a full cycle
    if (s.ctrl.channel_order) begin
      next_s.par_data = next_s.result.a; // R06 R07
    end else begin
      next_s.par_data = next_s.result.b; // R06 R07
    end

    // Master serial transfer
    case (s.ser)
      SR_IDLE: begin
        if (convert_request_n_fall && master) begin
          next_s.ser = SR_WAIT;
          if (s.ctrl.read_after) begin
            if (s.ctrl.reduced_power) begin
              next_s.ser_cnt = 8'(`DACS_CYC_DN(`DACS_RAC_RED_NS) - 1); // R15
            end else begin
              next_s.ser_cnt = 8'(`DACS_CYC_DN(`DACS_RAC_NRM_NS) - 1); // R15
            end
          end else begin
            // Read during convert sends the previous result
            sh_load = 1'b1;
            sh_data = ordered; // R18
            if (s.ctrl.reduced_power) begin
              next_s.ser_cnt = 8'(`DACS_CYC_DN(`DACS_RDC_RED_NS) - 1); // R08
            end else begin
              next_s.ser_cnt = 8'(`DACS_CYC_DN(`DACS_RDC_NRM_NS) - 1); // R08
            end
          end
        end
      end
      SR_WAIT: begin
        if (s.ser_cnt == 8'h00) begin
          next_s.sync = 1'b1; // R08 R15
          next_s.ser = SR_LEAD;
          next_s.ser_cnt = lead_cyc - 8'h01; // R13
        end else begin
          next_s.ser_cnt = s.ser_cnt - 8'h01;
        end
      end
      SR_LEAD: begin
        if (s.ser_cnt != 8'h00) begin
          next_s.ser_cnt = s.ser_cnt - 8'h01;
        end else if (!s.ctrl.read_after || s.conv == CV_HOLD) begin
          if (s.ctrl.read_after) begin
            sh_load = 1'b1;
            sh_data = ordered; // R18
          end
          next_s.ser = SR_SHIFT; // R13
          next_s.bit_cnt = 6'h00;
        end
      end
      SR_SHIFT: begin
        if (div_tick) begin
          if (!s.sclk) begin
            next_s.sclk = 1'b1; // R09 R10
          end else begin
            next_s.sclk = 1'b0;
            sh_shift = 1'b1;
            if (s.bit_cnt == 6'h1f) begin
              next_s.ser = SR_TRAIL;
              next_s.ser_cnt = trail_cyc - 8'h01; // R14
            end else begin
              next_s.bit_cnt = s.bit_cnt + 6'h01;
            end
          end
        end
      end
      SR_TRAIL: begin
        if (s.ser_cnt == 8'h00) begin
          next_s.sync = 1'b0; // R14
          next_s.ser = SR_DONE;
        end else begin
          next_s.ser_cnt = s.ser_cnt - 8'h01;
        end
      end
      SR_DONE: begin
        next_s.ser = SR_IDLE;
      end
      default: begin
        next_s.ser = SR_IDLE;
      end
    endcase
    // Leaving master mode drops any transfer in flight
    if (!master) begin
      next_s.ser = SR_IDLE; // R20
      next_s.sync = 1'b0;
      next_s.sclk = 1'b0;
    end

    // Slave serial: shift on a rising external clock; at most one bit per two pclk cycles
    if (slave && !serial_select_n && ext_sclk_in && !s.ext_sclk_q) begin
      sh_shift = 1'b1; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.convert_request_n_q <= 1'b1;
      s.ctrl <= dacs_ctrl_type'(`DACS_CTRL_RESET);
    end else begin
      s <= next_s;
    end
  end

  // Kept out of the main process: the divider tick it enables feeds back into that process
  assign div_en = (s.ser == SR_SHIFT);

  // APB answers with no wait state
  assign pready = 1'b1;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;

  assign busy = s.busy;
  assign eoc = s.eoc;

  assign par_data_out = s.par_data;
  assign par_data_oe = ~s.ctrl.port_type_select & ~serial_select_n; // R20

  assign serial_clk_out = s.sclk;
  assign serial_clk_oe = master & ~serial_select_n;
  assign frame_marker_out = s.sync;
  assign frame_marker_oe = master & ~serial_select_n;
  assign serial_result_out = sh_msb;
  assign serial_result_oe = s.ctrl.port_type_select & ~serial_select_n; // R20
endmodule

/* File: verif/dacs_sva.sv */
// Checker of the sequencer's pin timing, bound to dacs_top.
// Assumes pclk at 40 MHz, so one cycle is 25 ns.
`timescale 1ns/100ps
module dacs_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  // Conversion and result ports
  input wire logic        convert_request_n,
  input wire logic        busy,
  input wire logic        eoc,
  input wire logic [15:0] par_data_out,
  input wire logic        serial_clk_out,
  input wire logic        frame_marker_out
);
  logic [8:0] bcnt;
  logic [5:0] ecnt;

  // Mode bits are not visible here, so the widest limits of all modes apply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt <= 9'h000;
      ecnt <= 6'h00;
    end else begin
      bcnt <= busy ? bcnt + 9'h001 : 9'h000;
      ecnt <= eoc ? ecnt + 6'h01 : 6'h00;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_bound: assert property (bcnt <= 9'h1b8)
    else $error("busy high too long");
  a_eoc_width: assert property (ecnt <= 6'h32)
    else $error("end of conversion high too long");
  a_eoc_gap: assert property ($fell(eoc) |-> !eoc ##1 !eoc)
    else $error("gap between channels too short");
  a_busy_tail: assert property ($fell(busy) |-> !$past(eoc))
    else $error("busy fell with conversion end");
  a_start_resp: assert property ($fell(convert_request_n) && !busy |=> busy && eoc)
    else $error("request not answered");
  a_par_settled: assert property ($fell(busy) |-> $stable(par_data_out))
    else $error("parallel data changed at busy fall");
  a_sclk_framed: assert property ($rose(serial_clk_out) |-> frame_marker_out)
    else $error("serial clock outside frame");
  a_frame_lead: assert property ($rose(frame_marker_out) |-> !serial_clk_out ##1 !serial_clk_out)
    else $error("serial clock too soon after marker");
  a_frame_trail: assert property ($fell(frame_marker_out) |-> !serial_clk_out && !$past(serial_clk_out))
    else $error("marker fell too soon after clock");
  a_after_busy: assert property ($fell(frame_marker_out) && busy |=> !busy)
    else $error("busy late after frame end");
  a_bad_addr: assert property (psel && !penable && paddr >= 12'h00c |=> pslverr)
    else $error("unmapped address not refused");

  c_conv: cover property ($fell(busy));
  c_frame: cover property ($fell(frame_marker_out));
  c_err: cover property (pslverr);
endmodule

/* File: verif/dacs_host.sv */
// Host model: issues convert requests and receives the master serial stream.
// Assumes sclk, frame and sdo are the device's registered pclk-timed outputs.
`timescale 1ns/100ps
module dacs_host (
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Bench command
  input wire logic   go,
  // Device pins
  input wire logic   busy,
  input wire logic   sclk,
  input wire logic   frame,
  input wire logic   sdo,
  output logic       convert_request_n,
  // Received stream
  output logic [31:0] word,
  output int         min_per
);
  logic sclk_q;
  int   per;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convert_request_n <= 1'b1;
      sclk_q <= 1'b0;
      word <= 32'h0;
      per <= 0;
      min_per <= 999;
    end else begin
      // One-cycle request, never while a conversion runs
      convert_request_n <= !(go && !busy);
      sclk_q <= sclk;
      per <= per + 1;
      if (go)
        min_per <= 999;
      if (sclk && !sclk_q && frame) begin
        word <= {word[30:0], sdo};
        per <= 0;
        if (per + 1 < min_per)
          min_per <= per + 1;
      end
    end
  end
endmodule

/* File: verif/tb_dual_adc_conversion_sequencer.sv */
// Self-checking bench of dacs_top with the host model on its result ports.
// Assumes zero-wait APB and the mode bits of CTRL at offset 0.
`timescale 1ns/100ps
module tb_dual_adc_conversion_sequencer;
  import dacs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr;
  logic convert_request_n, busy, eoc, sck, fm, sdo, xs, poe, coe, foe, roe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hw;
  logic [15:0] pd;
  dacs_pair_type p1, p2;
  int mp, n_mismatch, comparisons;
  int ralim[2][4] = '{'{130, 170, 250, 430}, '{140, 180, 260, 440}};
  int pmin[4] = '{1, 2, 4, 8};

  dacs_top u_dacs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .convert_request_n, .pair1(p1), .pair2(p2), .busy, .eoc, .par_data_out(pd),
    .par_data_oe(poe), .serial_select_n(1'b0), .ext_sclk_in(xs), .serial_chain_in(1'b0),
    .serial_clk_out(sck), .serial_clk_oe(coe), .frame_marker_out(fm), .frame_marker_oe(foe),
    .serial_result_out(sdo), .serial_result_oe(roe));
  dacs_host u_dacs_host (.pclk, .presetn, .go, .busy, .sclk(sck), .frame(fm), .sdo,
    .convert_request_n, .word(hw), .min_per(mp));

  always #12.5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input int v);
    comparisons++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Runs one conversion and measures busy, both eoc pulses and the marker delay
  task automatic conv(input logic ser, output int nb, ea, gp, eb, fd);
    int seg;
    logic pe, sawb;
    nb = 0; ea = 0; gp = 0; eb = 0; fd = 0; seg = 0; pe = 0; sawb = 0;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (int i = 1; i < 700; i++) begin
      @(posedge pclk);
      #1;
      if (busy === 1'b1) begin
        nb++;
        sawb = 1;
      end
      if (eoc === 1'b1) begin
        if (seg == 0) ea++;
        else eb++;
      end else if (pe) seg++;
      if (seg == 1 && eoc !== 1'b1) gp++;
      pe = (eoc === 1'b1);
      if (fm === 1'b1 && fd == 0) fd = i;
      if (sawb && busy !== 1'b1 && fm !== 1'b1 && (!ser || fd > 0)) break;
    end
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(0, 12'h000, 0, q, e);
    chk("ctrl reset", 32'h0, q);
    apb(1, 12'h004, 32'hff, q, e);
    apb(0, 12'h004, 0, q, e);
    chk("status", 32'h0, q);
    apb(0, 12'h010, 0, q, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    apb(1, 12'h000, 32'ha5, q, e);
    apb(0, 12'h000, 0, q, e);
    chk("ctrl rw", 32'ha5, q);
    $display("test registers done");
  endtask

  task automatic t_par;
    logic [31:0] q;
    logic e, r, s, o;
    logic [2:0] cs[4];
    dacs_pair_type p;
    int nb, ea, gp, eb, fd;
    cs = '{3'b001, 3'b110, 3'b010, 3'b101};
    for (int k = 0; k < 4; k++) begin
      {r, s, o} = cs[k];
      p = s ? p2 : p1;
      apb(1, 12'h000, {24'h0, 4'h0, s, o, 1'b0, r}, q, e);
      conv(0, nb, ea, gp, eb, fd);
      rng("busy width", 1, r ? 80 : 70, nb);
      rng("first eoc", 1, r ? 50 : 40, ea);
      rng("eoc gap", 2, 99, gp);
      rng("second eoc", 1, 30, eb);
      chk("par data", o ? p.a : p.b, pd);
      chk("port enables", 4'b1000, {poe, coe, foe, roe});
      apb(0, 12'h008, 0, q, e);
      chk("result", p, q);
      apb(0, 12'h004, 0, q, e);
      chk("pair used", s, q[3]);
    end
    $display("test parallel done");
  endtask

  task automatic t_ser;
    logic [31:0] q;
    logic e, a, r, o;
    logic [1:0] d;
    logic [4:0] cs[4];
    int nb, ea, gp, eb, fd, fe;
    cs = '{5'b00001, 5'b01100, 5'b10001, 5'b11110};
    for (int k = 0; k < 4; k++) begin
      {a, r, d, o} = cs[k];
      fe = a ? (r ? 40 : 30) : (r ? 20 : 10);
      apb(1, 12'h000, {24'h0, d, a, 2'b00, o, 1'b1, r}, q, e);
      conv(1, nb, ea, gp, eb, fd);
      chk("serial word", o ? {p1.a, p1.b} : {p1.b, p1.a}, hw);
      chk("port enables", 4'b0111, {poe, coe, foe, roe});
      rng("sclk period", pmin[d], 99, mp);
      rng("marker delay", fe + 1, fe + 3, fd);
      if (a) rng("busy width", 1, ralim[r][d], nb);
      else rng("busy width", 1, r ? 80 : 70, nb);
    end
    $display("test serial done");
  endtask

  // Slave read: the bench clocks the loaded result out itself, high two cycles, low one
  task automatic t_slave;
    logic [31:0] q, w;
    logic e;
    int nb, ea, gp, eb, fd;
    apb(1, 12'h000, 32'h16, q, e);
    conv(0, nb, ea, gp, eb, fd);
    rng("busy width", 1, 70, nb);
    chk("port enables", 4'b0001, {poe, coe, foe, roe});
    for (int i = 0; i < 32; i++) begin
      @(posedge pclk);
      w = {w[30:0], sdo};
      xs <= 1'b1;
      repeat (2) @(posedge pclk);
      xs <= 1'b0;
    end
    chk("slave word", {p1.a, p1.b}, w);
    $display("test slave done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; go = 0;
    paddr = 12'h000; pwdata = 32'h0; n_mismatch = 0; comparisons = 0; xs = 0;
    p1 = {16'h1234, 16'hbeef};
    p2 = {16'h5a5a, 16'hc3c3};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_par();
    t_ser();
    t_slave();
    give_verdict();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
endmodule

bind dacs_top dacs_sva u_dacs_sva (.pclk, .presetn, .psel, .penable, .paddr, .pslverr, .convert_request_n,
  .busy, .eoc, .par_data_out, .serial_clk_out, .frame_marker_out);
